// *** src/cpu_special_registers.sv ***
/*
 * Program counter, stack pointer and processor status word of the core.
 * Assumes the instruction decoder issues one op per cycle with operands,
 * and that the stack memory returns two words at the stack pointer.
 */
// Summary of operation
// - Program counter is 20 bits, always even
// - Counter advances by instruction length, two to eight
// - Short branch and call clear upper four bits
// - Direct counter writes honour size; word clears top
// - Short call saves low sixteen, long call twenty
// - Long return reloads twenty bits, pointer plus four
// - Short return reloads sixteen bits, pointer plus two
// - Stack pointer predecrements on push, postincrements on pop
// - Stack pointer always even, loaded by software
// - Pushing pointer stores old value; popping itself loads
// - Status word operand only register mode, word size
// - Interrupt entry pushes counter and status with top bits
// - Interrupt return restores status and full counter
// - Vectors sit downward from top of low 64K
// - Add overflow on like signs giving other sign
// - Subtract overflow on unlike signs, wrong result sign
// - Zero, negative and carry follow the result
// - Interrupt enable bit gates maskable interrupts
// - Core halt bit stops the core
// - Clock gen one stops oscillator only when unused
// - Clock gen zero disables loop control
// - Crystal stop bit stops crystal only when unused
`timescale 1ns/1ps
module cpu_special_registers
	import csr_core_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic op_valid_i,
	input wire op_t op_i,
	input wire logic [3:0] op_len_i,
	input wire logic [19:0] target_i,
	input wire logic [19:0] data_i,
	input wire logic [15:0] dst_i,
	input wire logic [1:0] src_mode_i,
	input wire logic word_op_i,
	input wire logic push_self_i,
	input wire logic pop_self_i,
	input wire logic [31:0] stack_rdata_i,
	input wire logic [4:0] irq_num_i,
	input wire logic irq_req_i,
	input wire logic osc_in_use_i,
	input wire logic xtal_in_use_i,
	input wire logic cg_reg3_i,
	input wire logic [1:0] cg_size_i,
	output logic [19:0] pc_o,
	output logic [19:0] sp_o,
	output logic [15:0] psw_o,
	output logic [15:0] alu_result_o,
	output logic [19:0] stack_addr_o,
	output logic [31:0] stack_wdata_o,
	output logic stack_we_o,
	output logic stack_wide_o,
	output logic [19:0] pop_data_o,
	output logic pop_valid_o,
	output logic [19:0] vector_addr_o,
	output logic irq_accept_o,
	output logic core_halt_o,
	output logic osc_off_o,
	output logic loop_off_o,
	output logic xtal_off_o,
	output logic const_valid_o,
	output logic [19:0] const_val_o
);
	logic [19:0] pc_q, pc_d;
	logic [19:0] sp_q, sp_d;
	logic [15:0] psw_q, psw_d;
	logic [15:0] sum_res;
	logic sum_c, sum_z, sum_n, sum_v;
	logic is_alu, psw_wr_ok;
	logic cg_valid;
	logic [19:0] cg_value;
	logic [19:0] step;

	assign is_alu = op_valid_i && (op_i == OP_ADD || op_i == OP_SUB);
	assign psw_wr_ok = (src_mode_i == MODE_REGISTER) && word_op_i;
	assign step = {16'h0000, op_len_i} & EVEN_MASK;

	arith_flags u_arith (
		.dst_i(dst_i),
		.src_i(data_i[15:0]),
		.sub_i(op_i == OP_SUB),
		.result_o(sum_res),
		.carry_o(sum_c),
		.zero_o(sum_z),
		.neg_o(sum_n),
		.ovf_o(sum_v)
	);

	const_source u_const (
		.reg3_i(cg_reg3_i),
		.mode_i(src_mode_i),
		.size_i(cg_size_i),
		.valid_o(cg_valid),
		.value_o(cg_value)
	);

	// Program counter next value
	always_comb begin
		pc_d = pc_q;
		if (op_valid_i) begin
			case (op_i)
				OP_STEP: pc_d = pc_q + step;
				OP_SHORT_BRANCH, OP_SHORT_CALL, OP_PC_WRITE_WORD:
					pc_d = target_i & LOW_64K_MASK;
				OP_LONG_BRANCH, OP_LONG_CALL, OP_PC_WRITE_ADDR:
					pc_d = target_i;
				OP_SHORT_RETURN:
					pc_d = {4'h0, stack_rdata_i[15:0]};
				OP_LONG_RETURN:
					pc_d = {stack_rdata_i[19:16], stack_rdata_i[15:0]};
				OP_IRQ_ENTRY:
					pc_d = target_i & LOW_64K_MASK;
				OP_IRQ_RETURN:
					pc_d = {stack_rdata_i[15:12], stack_rdata_i[31:16]};
				default: pc_d = pc_q;
			endcase
		end
		pc_d = pc_d & EVEN_MASK;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pc_q <= PC_RESET;
		end else begin
			pc_q <= pc_d;
		end
	end

	// Stack pointer next value
	always_comb begin
		sp_d = sp_q;
		if (op_valid_i) begin
			case (op_i)
				OP_SHORT_CALL, OP_PUSH: sp_d = sp_q - STEP_WORD;
				OP_LONG_CALL, OP_IRQ_ENTRY: sp_d = sp_q - STEP_ADDR;
				OP_SHORT_RETURN: sp_d = sp_q + STEP_WORD;
				OP_LONG_RETURN, OP_IRQ_RETURN: sp_d = sp_q + STEP_ADDR;
				// Popping into itself keeps the loaded value
				OP_POP: sp_d = pop_self_i ? {4'h0, stack_rdata_i[15:0]} :
					sp_q + STEP_WORD;
				OP_SP_LOAD: sp_d = data_i;
				default: sp_d = sp_q;
			endcase
		end
		sp_d = sp_d & EVEN_MASK;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sp_q <= SP_RESET;
		end else begin
			sp_q <= sp_d;
		end
	end

	// Status word next value
	always_comb begin
		psw_d = psw_q;
		if (is_alu) begin
			psw_d[CARRY_POS] = sum_c;
			psw_d[ZERO_POS] = sum_z;
			psw_d[NEG_POS] = sum_n;
			psw_d[OVF_POS] = sum_v;
		end else if (op_valid_i && op_i == OP_PSW_WRITE && psw_wr_ok) begin
			psw_d = data_i[15:0];
		end else if (op_valid_i && op_i == OP_IRQ_RETURN) begin
			psw_d = {4'h0, stack_rdata_i[11:0]};
		end else if (op_valid_i && op_i == OP_IRQ_ENTRY) begin
			// Handler starts with maskable interrupts off and core awake
			psw_d[IRQ_EN_POS] = 1'b0;
			psw_d[HALT_POS] = 1'b0;
		end
		psw_d = psw_d & PSW_WRITABLE;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			psw_q <= PSW_RESET;
		end else begin
			psw_q <= psw_d;
		end
	end

	// Stack write port
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			stack_we_o <= 1'b0;
			stack_wide_o <= 1'b0;
			stack_addr_o <= 20'h00000;
			stack_wdata_o <= 32'h00000000;
		end else begin
			stack_we_o <= 1'b0;
			stack_wide_o <= 1'b0;
			if (op_valid_i) begin
				case (op_i)
					OP_SHORT_CALL: begin
						stack_we_o <= 1'b1;
						stack_addr_o <= sp_q - STEP_WORD;
						stack_wdata_o <= {16'h0000, pc_q[15:0]};
					end
					OP_PUSH: begin
						stack_we_o <= 1'b1;
						stack_addr_o <= sp_q - STEP_WORD;
						// Pointer pushes its value from before the push
						stack_wdata_o <= push_self_i ?
							{16'h0000, sp_q[15:0]} :
							{16'h0000, data_i[15:0]};
					end
					OP_LONG_CALL: begin
						stack_we_o <= 1'b1;
						stack_wide_o <= 1'b1;
						stack_addr_o <= sp_q - STEP_ADDR;
						stack_wdata_o <= {12'h000, pc_q};
					end
					OP_IRQ_ENTRY: begin
						stack_we_o <= 1'b1;
						stack_wide_o <= 1'b1;
						stack_addr_o <= sp_q - STEP_ADDR;
						stack_wdata_o <= {pc_q[15:0], pc_q[19:16],
							psw_q[11:0]};
					end
					default: stack_we_o <= 1'b0;
				endcase
			end
		end
	end

	// Pop result for ordinary destinations
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pop_valid_o <= 1'b0;
			pop_data_o <= 20'h00000;
		end else begin
			pop_valid_o <= op_valid_i && op_i == OP_POP;
			pop_data_o <= {4'h0, stack_rdata_i[15:0]};
		end
	end

	// Flag arithmetic result
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			alu_result_o <= 16'h0000;
		end else if (is_alu) begin
			alu_result_o <= sum_res;
		end
	end

	// Vector address and interrupt gating
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			vector_addr_o <= VECTOR_TOP;
			irq_accept_o <= 1'b0;
		end else begin
			vector_addr_o <= VECTOR_TOP - {14'h0000, irq_num_i, 1'b0};
			irq_accept_o <= irq_req_i && psw_d[IRQ_EN_POS];
		end
	end

	// Low-power controls; a clock source in use is never stopped
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			core_halt_o <= 1'b0;
			osc_off_o <= 1'b0;
			loop_off_o <= 1'b0;
			xtal_off_o <= 1'b0;
		end else begin
			core_halt_o <= psw_d[HALT_POS];
			osc_off_o <= psw_d[CLK_GEN1_POS] && !osc_in_use_i;
			loop_off_o <= psw_d[CLK_GEN0_POS];
			xtal_off_o <= psw_d[XTAL_STOP_POS] && !xtal_in_use_i;
		end
	end

	// Constant operand in place of the status word or constant register
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			const_valid_o <= 1'b0;
			const_val_o <= 20'h00000;
		end else begin
			const_valid_o <= cg_valid;
			const_val_o <= cg_value;
		end
	end

	assign pc_o = pc_q;
	assign sp_o = sp_q;
	assign psw_o = psw_q;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_op(op_t o);
		op_valid_i && op_i == o;
	endsequence

	sequence s_word_push;
		s_op(OP_PUSH) or s_op(OP_SHORT_CALL);
	endsequence

	chk_pc_even: assert property (pc_q[0] == 1'b0)
		else $error("pc odd");
	chk_pc_step: assert property (s_op(OP_STEP) |=>
		pc_q == (($past(pc_q) + $past(step)) & EVEN_MASK))
		else $error("pc step wrong");
	chk_short_branch: assert property (s_op(OP_SHORT_BRANCH) |=>
		pc_q[19:16] == 4'h0)
		else $error("short branch upper bits set");
	chk_word_pc_write: assert property (s_op(OP_PC_WRITE_WORD) |=>
		pc_q == ($past(target_i) & LOW_64K_MASK & EVEN_MASK))
		else $error("word pc write wrong");
	chk_short_call: assert property (s_op(OP_SHORT_CALL) |=>
		stack_we_o && !stack_wide_o && stack_wdata_o[15:0] == $past(pc_q[15:0]))
		else $error("short call push wrong");
	chk_long_ret: assert property (s_op(OP_LONG_RETURN) |=>
		sp_q == $past(sp_q) + STEP_ADDR)
		else $error("long return pointer wrong");
	chk_short_ret: assert property (s_op(OP_SHORT_RETURN) |=>
		sp_q == $past(sp_q) + STEP_WORD && pc_q[19:16] == 4'h0)
		else $error("short return wrong");
	chk_push_predec: assert property (s_word_push |=>
		stack_addr_o == sp_q && stack_we_o)
		else $error("push not predecremented");
	chk_sp_even: assert property (sp_q[0] == 1'b0)
		else $error("sp odd");
	chk_pop_self: assert property (s_op(OP_POP) and pop_self_i |=>
		sp_q == ({4'h0, $past(stack_rdata_i[15:0])} & EVEN_MASK))
		else $error("pop into pointer wrong");
	chk_irq_frame: assert property (s_op(OP_IRQ_ENTRY) |=>
		stack_wide_o && stack_wdata_o[15:12] == $past(pc_q[19:16]))
		else $error("irq frame wrong");
	chk_irq_ret: assert property (s_op(OP_IRQ_RETURN) |=>
		pc_q[19:16] == $past(stack_rdata_i[15:12]))
		else $error("irq return pc wrong");
	chk_irq_gate: assert property (irq_accept_o |-> psw_q[IRQ_EN_POS])
		else $error("irq accepted while disabled");
	chk_osc_keep: assert property (osc_in_use_i |=> !osc_off_o)
		else $error("oscillator stopped in use");
	chk_reserved: assert property (psw_q[15:9] == 7'h00)
		else $error("reserved status bits set");
endmodule : cpu_special_registers

// *** src/csr_core_pkg.sv ***
/*
 * Shared constants for the core's dedicated registers: widths, reset
 * values, status word layout, stack step sizes, operation codes.
 * Assumes a single clock and a synchronous active-high reset.
 */
package csr_core_pkg;
	localparam int ADDR_W = 20;
	localparam int WORD_W = 16;

	localparam logic [19:0] PC_RESET = 20'h00000;
	localparam logic [19:0] SP_RESET = 20'h00000;
	localparam logic [15:0] PSW_RESET = 16'h0000;
	localparam logic [15:0] PSW_WRITABLE = 16'h01ff;

	localparam int CARRY_POS = 0;
	localparam int ZERO_POS = 1;
	localparam int NEG_POS = 2;
	localparam int IRQ_EN_POS = 3;
	localparam int HALT_POS = 4;
	localparam int XTAL_STOP_POS = 5;
	localparam int CLK_GEN0_POS = 6;
	localparam int CLK_GEN1_POS = 7;
	localparam int OVF_POS = 8;

	localparam logic [19:0] STEP_WORD = 20'h00002;
	localparam logic [19:0] STEP_ADDR = 20'h00004;
	localparam logic [19:0] VECTOR_TOP = 20'h0fffe;
	localparam logic [19:0] EVEN_MASK = 20'hffffe;
	localparam logic [19:0] LOW_64K_MASK = 20'h0ffff;

	localparam logic [1:0] MODE_REGISTER = 2'h0;

	typedef enum logic [4:0] {
		OP_STEP,
		OP_SHORT_BRANCH,
		OP_LONG_BRANCH,
		OP_PC_WRITE_WORD,
		OP_PC_WRITE_ADDR,
		OP_SHORT_CALL,
		OP_LONG_CALL,
		OP_SHORT_RETURN,
		OP_LONG_RETURN,
		OP_PUSH,
		OP_POP,
		OP_SP_LOAD,
		OP_IRQ_ENTRY,
		OP_IRQ_RETURN,
		OP_ADD,
		OP_SUB,
		OP_PSW_WRITE
	} op_t;
endpackage : csr_core_pkg

// *** src/arith_flags.sv ***
/*
 * Word adder and subtractor with status flag results.
 * Assumes operands are stable for the cycle in which they are sampled.
 */
`timescale 1ns/1ps
module arith_flags
	import csr_core_pkg::*;
(
	input wire logic [15:0] dst_i,
	input wire logic [15:0] src_i,
	input wire logic sub_i,
	output logic [15:0] result_o,
	output logic carry_o,
	output logic zero_o,
	output logic neg_o,
	output logic ovf_o
);
	logic [15:0] opnd;
	logic [16:0] sum;

	always_comb begin
		// Subtract as dst + not src + 1, so carry means no borrow
		opnd = sub_i ? ~src_i : src_i;
		sum = {1'b0, dst_i} + {1'b0, opnd} + {16'h0000, sub_i};
		result_o = sum[15:0];
		carry_o = sum[16];
		zero_o = (sum[15:0] == 16'h0000);
		neg_o = sum[15];
		// Same-sign effective operands giving the other sign
		ovf_o = (dst_i[15] == opnd[15]) && (sum[15] != dst_i[15]);
	end
endmodule : arith_flags

// *** src/const_source.sv ***
/*
 * Constant generator values selected by source mode on the status word
 * and constant registers. Assumes the decoder flags the selected register.
 */
`timescale 1ns/1ps
module const_source
	import csr_core_pkg::*;
(
	input wire logic reg3_i,
	input wire logic [1:0] mode_i,
	input wire logic [1:0] size_i,
	output logic valid_o,
	output logic [19:0] value_o
);
	always_comb begin
		valid_o = 1'b1;
		value_o = 20'h00000;
		case ({reg3_i, mode_i})
			3'h0: valid_o = 1'b0;
			3'h1: value_o = 20'h00000;
			3'h2: value_o = 20'h00004;
			3'h3: value_o = 20'h00008;
			3'h4: value_o = 20'h00000;
			3'h5: value_o = 20'h00001;
			3'h6: value_o = 20'h00002;
			// All ones at the operand size: byte, word, address-word
			3'h7: value_o = (size_i == 2'h0) ? 20'h000ff :
				(size_i == 2'h1) ? 20'h0ffff : 20'hfffff;
			default: valid_o = 1'b0;
		endcase
	end
endmodule : const_source

// *** dv/testbench.sv ***
/*
 * Self-checking bench for the core's dedicated registers: ops are driven
 * at the rising edge, expected outputs queued, compared at falling edge.
 * Assumes one op taken per edge with results visible one cycle later.
 */
`timescale 1ns/1ps
module testbench
	import csr_core_pkg::*;
;
	localparam int PCO = 0, SPO = 1, PSWO = 2, ALUO = 3, SAO = 4, SWO = 5;
	localparam int WEO = 6, WIDEO = 7, POPDO = 8, POPVO = 9, VECO = 10;
	localparam int ACCO = 11, HALTO = 12, OSCO = 13, LOOPO = 14, XTALO = 15;
	localparam int CVO = 16, CVALO = 17;
	typedef struct {int sel; logic [31:0] want; logic [31:0] mask;} note_t;
	string sig_names [18] = '{"pc", "sp", "psw", "alu", "stack_addr",
		"stack_wdata", "stack_we", "stack_wide", "pop_data", "pop_valid",
		"vector_addr", "irq_accept", "core_halt", "osc_off", "loop_off",
		"xtal_off", "const_valid", "const_val"};
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic op_valid_i = 1'b0;
	op_t op_i = OP_STEP;
	logic [3:0] op_len_i = 4'h2;
	logic [19:0] target_i = 20'h00000;
	logic [19:0] data_i = 20'h00000;
	logic [15:0] dst_i = 16'h0000;
	logic [1:0] src_mode_i = 2'h0;
	logic word_op_i = 1'b1;
	logic push_self_i = 1'b0;
	logic pop_self_i = 1'b0;
	logic [31:0] stack_rdata_i = 32'h00000000;
	logic [4:0] irq_num_i = 5'h00;
	logic irq_req_i = 1'b0;
	logic osc_in_use_i = 1'b0;
	logic xtal_in_use_i = 1'b0;
	logic cg_reg3_i = 1'b0;
	logic [1:0] cg_size_i = 2'h1;
	logic [19:0] pc_o, sp_o, stack_addr_o, pop_data_o, vector_addr_o;
	logic [19:0] const_val_o;
	logic [15:0] psw_o, alu_result_o;
	logic [31:0] stack_wdata_o;
	logic stack_we_o, stack_wide_o, pop_valid_o, irq_accept_o, core_halt_o;
	logic osc_off_o, loop_off_o, xtal_off_o, const_valid_o;
	logic [31:0] obs [18];
	note_t notes_q [$];
	note_t cur;
	logic [31:0] got;
	int checks = 0;
	int mismatches = 0;
	logic [19:0] pc_m, sp_m, fl;
	logic [15:0] psw_m, rnd_q, opa, opb;
	logic [15:0] av [6] = '{16'h7fff, 16'hffff, 16'h8000, 16'h8000,
		16'h0005, 16'h7fff};
	logic [15:0] bv [6] = '{16'h0001, 16'h0001, 16'h8000, 16'h0001,
		16'h0005, 16'hffff};

	cpu_special_registers dut (.sys_clk_i, .srst_i, .op_valid_i, .op_i,
		.op_len_i, .target_i, .data_i, .dst_i, .src_mode_i, .word_op_i,
		.push_self_i, .pop_self_i, .stack_rdata_i, .irq_num_i, .irq_req_i,
		.osc_in_use_i, .xtal_in_use_i, .cg_reg3_i, .cg_size_i, .pc_o, .sp_o,
		.psw_o, .alu_result_o, .stack_addr_o, .stack_wdata_o, .stack_we_o,
		.stack_wide_o, .pop_data_o, .pop_valid_o, .vector_addr_o,
		.irq_accept_o, .core_halt_o, .osc_off_o, .loop_off_o, .xtal_off_o,
		.const_valid_o, .const_val_o);

	always #50 sys_clk_i = ~sys_clk_i;

	always_comb obs = '{32'(pc_o), 32'(sp_o), 32'(psw_o), 32'(alu_result_o),
		32'(stack_addr_o), stack_wdata_o, 32'(stack_we_o), 32'(stack_wide_o),
		32'(pop_data_o), 32'(pop_valid_o), 32'(vector_addr_o),
		32'(irq_accept_o), 32'(core_halt_o), 32'(osc_off_o), 32'(loop_off_o),
		32'(xtal_off_o), 32'(const_valid_o), 32'(const_val_o)};

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Packs {result, v, n, z, c}; carry on subtract means no borrow
	function automatic logic [19:0] flags(input logic [15:0] d,
		input logic [15:0] s, input logic sub);
		logic [16:0] r;
		logic v;
		r = sub ? {1'b0, d} - {1'b0, s} : {1'b0, d} + {1'b0, s};
		v = (sub ? (d[15] != s[15]) : (d[15] == s[15])) &&
			(r[15] != d[15]);
		return {r[15:0], v, r[15], r[15:0] == 16'h0000, sub ^ r[16]};
	endfunction : flags

	task automatic note(input int sel, input logic [31:0] want,
		input logic [31:0] mask = 32'hffffffff);
		notes_q.push_back('{sel, want, mask});
	endtask : note

	task automatic issue(input op_t op, input logic [19:0] tgt,
		input logic [19:0] dat);
		op_valid_i <= 1'b1;
		op_i <= op;
		target_i <= tgt;
		data_i <= dat;
		@(posedge sys_clk_i);
	endtask : issue

	task automatic idle();
		op_valid_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : idle

	task automatic cg_case(input logic r3, input logic [1:0] mode,
		input logic [1:0] size, input logic ok, input logic [19:0] val);
		cg_reg3_i <= r3;
		src_mode_i <= mode;
		cg_size_i <= size;
		@(posedge sys_clk_i);
		note(CVO, 32'(ok));
		if (ok) begin
			note(CVALO, 32'(val));
		end
	endtask : cg_case

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	// Oldest note first; every note belongs to the edge just before
	always @(negedge sys_clk_i) begin
		while (notes_q.size() > 0) begin
			cur = notes_q.pop_front();
			got = obs[cur.sel] & cur.mask;
			checks++;
			if (got !== (cur.want & cur.mask)) begin
				mismatches++;
				$display("unexpected %s: expected %h, seen %h",
					sig_names[cur.sel], cur.want & cur.mask, got);
			end
		end
	end

	// Whole run is under a hundred cycles; timeout at 20000 cycles is a generous margin
	initial begin
		#(100 * 20000);
		mismatches++;
		stop_test();
	end

	initial begin
		rnd_q = 16'h0061;
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		note(PCO, 32'h0);
		note(SPO, 32'h0);
		note(PSWO, 32'h0);
		note(VECO, 32'h0fffe);
		rnd_q = lfsr(rnd_q);
		issue(OP_SP_LOAD, 20'h0, {4'h2, rnd_q | 16'h0001});
		sp_m = {4'h2, rnd_q} & EVEN_MASK;
		note(SPO, 32'(sp_m));
		pc_m = PC_RESET;
		for (int i = 1; i <= 4; i++) begin
			op_len_i <= 4'(2 * i);
			issue(OP_STEP, 20'h0, 20'h0);
			pc_m = pc_m + 20'(2 * i);
			note(PCO, 32'(pc_m));
		end
		issue(OP_LONG_BRANCH, 20'hf1235, 20'h0);
		note(PCO, 32'hf1234);
		issue(OP_PC_WRITE_WORD, 20'hf5678, 20'h0);
		note(PCO, 32'h05678);
		issue(OP_PC_WRITE_ADDR, 20'hf5678, 20'h0);
		note(PCO, 32'hf5678);
		issue(OP_SHORT_BRANCH, 20'he9abc, 20'h0);
		note(PCO, 32'h09abc);
		issue(OP_LONG_BRANCH, 20'ha4320, 20'h0);
		issue(OP_SHORT_CALL, 20'h71112, 20'h0);
		sp_m = sp_m - STEP_WORD;
		note(PCO, 32'h01112);
		note(SPO, 32'(sp_m));
		note(SAO, 32'(sp_m));
		note(SWO, 32'h4320, 32'h0000ffff);
		note(WEO, 32'h1);
		idle();
		note(WEO, 32'h0);
		issue(OP_LONG_BRANCH, 20'hb2468, 20'h0);
		issue(OP_LONG_CALL, 20'h3579a, 20'h0);
		sp_m = sp_m - STEP_ADDR;
		note(PCO, 32'h3579a);
		note(SAO, 32'(sp_m));
		note(SWO, 32'h000b2468);
		note(WIDEO, 32'h1);
		stack_rdata_i <= 32'hfff58642;
		issue(OP_LONG_RETURN, 20'h0, 20'h0);
		sp_m = sp_m + STEP_ADDR;
		note(PCO, 32'h58642);
		note(SPO, 32'(sp_m));
		stack_rdata_i <= 32'h00031358;
		issue(OP_SHORT_RETURN, 20'h0, 20'h0);
		sp_m = sp_m + STEP_WORD;
		note(PCO, 32'h1358, 32'h0000ffff);
		note(SPO, 32'(sp_m));
		issue(OP_PUSH, 20'h0, 20'h2abcd);
		sp_m = sp_m - STEP_WORD;
		note(SPO, 32'(sp_m));
		note(SWO, 32'habcd, 32'h0000ffff);
		push_self_i <= 1'b1;
		issue(OP_PUSH, 20'h0, 20'h0);
		note(SWO, 32'(sp_m[15:0]), 32'h0000ffff);
		sp_m = sp_m - STEP_WORD;
		note(SPO, 32'(sp_m));
		push_self_i <= 1'b0;
		stack_rdata_i <= 32'h00004455;
		issue(OP_POP, 20'h0, 20'h0);
		note(POPDO, 32'h4455, 32'h0000ffff);
		note(POPVO, 32'h1);
		note(SPO, 32'(sp_m + STEP_WORD));
		pop_self_i <= 1'b1;
		stack_rdata_i <= 32'h00007e10;
		issue(OP_POP, 20'h0, 20'h0);
		note(SPO, 32'h07e10);
		pop_self_i <= 1'b0;
		sp_m = 20'h07e10;
		word_op_i <= 1'b0;
		issue(OP_PSW_WRITE, 20'h0, 20'h0ffff);
		note(PSWO, 32'h0);
		word_op_i <= 1'b1;
		src_mode_i <= 2'h1;
		issue(OP_PSW_WRITE, 20'h0, 20'h0ffff);
		note(PSWO, 32'h0);
		src_mode_i <= MODE_REGISTER;
		irq_req_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			osc_in_use_i <= i[0];
			xtal_in_use_i <= i[1];
			issue(OP_PSW_WRITE, 20'h0, 20'hfffff);
			note(PSWO, 32'h01ff);
			note(HALTO, 32'h1);
			note(LOOPO, 32'h1);
			note(OSCO, 32'(!i[0]));
			note(XTALO, 32'(!i[1]));
			note(ACCO, 32'h1);
		end
		issue(OP_PSW_WRITE, 20'h0, 20'h0fff7);
		note(ACCO, 32'h0);
		issue(OP_PSW_WRITE, 20'h0, 20'h00008);
		note(HALTO, 32'h0);
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 8; i++) begin
				rnd_q = lfsr(rnd_q);
				opa = (i < 6) ? av[i] : rnd_q;
				rnd_q = lfsr(rnd_q);
				opb = (i < 6) ? bv[i] : rnd_q;
				dst_i <= opa;
				fl = flags(opa, opb, s[0]);
				issue(s[0] ? OP_SUB : OP_ADD, 20'h0, {4'h0, opb});
				note(ALUO, 32'(fl[19:4]));
				note(PSWO, {23'h0, fl[3], 5'h0, fl[2:0]}, 32'h0107);
			end
		end
		psw_m = {7'h0, fl[3], 4'h0, 1'b1, fl[2:0]};
		issue(OP_LONG_BRANCH, 20'h6a46e, 20'h0);
		irq_num_i <= 5'h03;
		issue(OP_IRQ_ENTRY, 20'h08000, 20'h0);
		sp_m = sp_m - STEP_ADDR;
		note(SAO, 32'(sp_m));
		note(WIDEO, 32'h1);
		note(SWO, {16'ha46e, 4'h6, psw_m[11:0]});
		note(PCO, 32'h08000);
		note(VECO, 32'h0fff8);
		stack_rdata_i <= {16'ha46e, 4'h6, psw_m[11:0]};
		issue(OP_IRQ_RETURN, 20'h0, 20'h0);
		note(PCO, 32'h6a46e);
		note(PSWO, 32'(psw_m));
		note(SPO, 32'(sp_m + STEP_ADDR));
		note(ACCO, 32'h1);
		irq_req_i <= 1'b0;
		idle();
		note(ACCO, 32'h0);
		cg_case(1'b0, 2'h0, 2'h1, 1'b0, 20'h0);
		cg_case(1'b0, 2'h1, 2'h1, 1'b1, 20'h00000);
		cg_case(1'b0, 2'h2, 2'h1, 1'b1, 20'h00004);
		cg_case(1'b0, 2'h3, 2'h1, 1'b1, 20'h00008);
		cg_case(1'b1, 2'h0, 2'h1, 1'b1, 20'h00000);
		cg_case(1'b1, 2'h1, 2'h1, 1'b1, 20'h00001);
		cg_case(1'b1, 2'h2, 2'h1, 1'b1, 20'h00002);
		cg_case(1'b1, 2'h3, 2'h0, 1'b1, 20'h000ff);
		cg_case(1'b1, 2'h3, 2'h1, 1'b1, 20'h0ffff);
		cg_case(1'b1, 2'h3, 2'h2, 1'b1, 20'hfffff);
		@(negedge sys_clk_i);
		#1;
		stop_test();
	end
endmodule : testbench
